// [hw/adc_cal_output_ctrl.sv]
// Calibration sequencing and output control of the sampling converter
`timescale 1ns/10ps
module adc_cal_output_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int CAL_LOW_MIN = CAL_LOW_MIN_DEF,
  parameter int CAL_HIGH_MIN = CAL_HIGH_MIN_DEF,
  parameter int CAL_CYCLES = CAL_CYCLES_DEF,
  parameter int TRIM_CYCLES = TRIM_CYCLES_DEF,
  parameter int DELAY_SHORT = DELAY_SHORT_DEF,
  parameter int DELAY_LONG = DELAY_LONG_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Sample clock and converter core
  input wire logic sample_clock,
  input wire logic [CODE_W-1:0] core_code,
  input wire logic core_below,
  input wire logic core_above,
  // Control pins
  input wire logic calibrate,
  input wire logic sleep_request,
  input wire logic power_up_delay_select,
  input wire logic full_scale_select,
  input wire logic output_swing_select,
  input wire logic launch_edge_select,
  input wire logic extended_mode,
  // Register port
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [REG_DATA_W-1:0] reg_rdata,
  // Output buses
  output logic [CODE_W-1:0] primary_output_bus,
  output logic [CODE_W-1:0] delayed_output_bus,
  output logic out_of_range,
  output logic forwarded_output_clock,
  output logic output_enable,
  output logic data_valid,
  // Status and analog settings
  output logic calibration_active,
  output logic trim_active,
  output logic output_swing_normal,
  output logic full_scale_normal
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = CODE_W + 10;

  logic [SYNC_W-1:0] pin_meta;
  logic [SYNC_W-1:0] pin_sync;
  logic sclk_prev;
  logic sclk_s, cal_s, sleep_s, dsel_s, fsr_s, swing_s, edge_s, ext_s;
  logic below_s, above_s;
  logic [CODE_W-1:0] code_s;

  // Core bits are only looked at on a sample edge, long after they settle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {sample_clock, calibrate, sleep_request,
                   power_up_delay_select, full_scale_select,
                   output_swing_select, launch_edge_select,
                   extended_mode, core_below, core_above, core_code};
      pin_sync <= pin_meta;
    end
  end

  assign {sclk_s, cal_s, sleep_s, dsel_s, fsr_s, swing_s, edge_s, ext_s,
          below_s, above_s, code_s} = pin_sync;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  logic smp_fall;
  assign smp_fall = sclk_prev & ~sclk_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  function automatic logic [CNT_W-1:0] cnt_of(input int n);
    return CNT_W'(n);
  endfunction : cnt_of

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [REG_DATA_W-1:0] config_reg;
  logic [REG_DATA_W-1:0] status_word;
  cal_state_e state;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      config_reg <= CFG_RESET;
    end else if (reg_write && reg_addr == REG_CONFIG) begin
      config_reg <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_read && reg_addr == REG_CONFIG) begin
      reg_rdata <= config_reg;
    end else if (reg_read && reg_addr == REG_STATUS) begin
      reg_rdata <= status_word;
    end else begin
      reg_rdata <= '0;
    end
  end

  // Mode is read live; a mid-run change is the controller's fault
  logic eff_swing, eff_edge, eff_fsr, eff_long;
  assign eff_swing = ext_s ? config_reg[CFG_SWING] : swing_s;
  assign eff_edge = ext_s ? config_reg[CFG_EDGE] : edge_s;
  assign eff_fsr = ext_s ? config_reg[CFG_FSR] : fsr_s;
  assign eff_long = ext_s ? 1'b0 : dsel_s;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      output_swing_normal <= 1'b1;
      full_scale_normal <= 1'b1;
    end else begin
      output_swing_normal <= eff_swing;
      full_scale_normal <= eff_fsr;
    end
  end

  // ----------------------------------------------------------------
  // Calibrate command detector
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] high_cnt;
  logic armed;
  logic cal_cmd;
  logic armed_now;
  logic [CNT_W-1:0] next_high;

  // Sleep requested outside a calibration already counts as asleep
  logic asleep;
  assign asleep = (state == S_SLEEP) || (sleep_s && state != S_CAL);

  assign armed_now = armed | (low_cnt >= cnt_of(CAL_LOW_MIN));
  assign next_high = sat_inc(high_cnt);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= '0;
      high_cnt <= '0;
      armed <= 1'b0;
      cal_cmd <= 1'b0;
    end else begin
      cal_cmd <= 1'b0;
      if (asleep) begin
        low_cnt <= '0;
        high_cnt <= '0;
        armed <= 1'b0;
      end else if (smp_fall && !cal_s) begin
        low_cnt <= sat_inc(low_cnt);
        high_cnt <= '0;
        armed <= 1'b0;
      end else if (smp_fall && armed_now) begin
        low_cnt <= '0;
        if (next_high >= cnt_of(CAL_HIGH_MIN)) begin
          cal_cmd <= 1'b1;
          armed <= 1'b0;
          high_cnt <= '0;
        end else begin
          armed <= 1'b1;
          high_cnt <= next_high;
        end
      end else if (smp_fall) begin
        low_cnt <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] seq_cnt;
  logic [CNT_W-1:0] delay_last;

  assign delay_last = eff_long ? cnt_of(DELAY_LONG - 1)
                               : cnt_of(DELAY_SHORT - 1);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_CHECK;
      seq_cnt <= '0;
    end else begin
      case (state)
        S_CHECK: begin
          // First sample edge after power-up catches the calibrate level
          if (smp_fall) begin
            state <= cal_s ? S_HOLD : S_DELAY;
          end
        end
        S_DELAY: begin
          if (smp_fall && !sleep_s) begin
            if (seq_cnt >= delay_last) begin
              state <= S_CAL;
              seq_cnt <= '0;
            end else begin
              seq_cnt <= sat_inc(seq_cnt);
            end
          end
        end
        S_HOLD: begin
          if (cal_cmd && !sleep_s) begin
            state <= S_CAL;
            seq_cnt <= '0;
          end
        end
        S_IDLE: begin
          if (sleep_s) begin
            state <= S_SLEEP;
          end else if (cal_cmd) begin
            state <= S_CAL;
            seq_cnt <= '0;
          end
        end
        S_CAL: begin
          if (smp_fall) begin
            if (seq_cnt >= cnt_of(CAL_CYCLES - 1)) begin
              state <= sleep_s ? S_SLEEP : S_IDLE;
              seq_cnt <= '0;
            end else begin
              seq_cnt <= sat_inc(seq_cnt);
            end
          end
        end
        S_SLEEP: begin
          if (!sleep_s) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_CHECK;
          seq_cnt <= '0;
        end
      endcase
    end
  end

  logic trim;
  assign trim = (state == S_CAL) && (seq_cnt < cnt_of(TRIM_CYCLES));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      calibration_active <= 1'b0;
      trim_active <= 1'b0;
      output_enable <= 1'b0;
    end else begin
      calibration_active <= (state == S_CAL);
      trim_active <= trim;
      output_enable <= !asleep;
    end
  end

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  pipe_if #(.W(WORD_W)) pipe ();

  sample_delay_line #(
    .W(WORD_W),
    .DEPTH(DELAYED_LATENCY),
    .TAP_P(PRIMARY_LATENCY),
    .TAP_D(DELAYED_LATENCY)
  ) u_line (
    .mclk(mclk),
    .rst_b(rst_b),
    .pipe(pipe.line)
  );

  // Trim stops the pipeline shift and the output clock; the sequencer keeps counting
  assign pipe.shift = smp_fall && !trim && (state != S_SLEEP);
  // Code passes through as offset binary; only the range ends clamp
  assign pipe.din = below_s ? {1'b1, CODE_MIN} :
                    above_s ? {1'b1, CODE_MAX} :
                    {1'b0, code_s};

  logic launch;
  logic [FILL_W-1:0] fill;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      forwarded_output_clock <= 1'b0;
      launch <= 1'b0;
    end else begin
      launch <= pipe.shift && ((~forwarded_output_clock) == eff_edge);
      if (pipe.shift) begin
        forwarded_output_clock <= ~forwarded_output_clock;
      end
    end
  end

  // Buses change one system clock after the chosen output clock edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      primary_output_bus <= '0;
      delayed_output_bus <= '0;
      out_of_range <= 1'b0;
    end else if (launch) begin
      primary_output_bus <= pipe.tap_primary[CODE_W-1:0];
      delayed_output_bus <= pipe.tap_delayed[CODE_W-1:0];
      out_of_range <= pipe.tap_primary[CODE_W] |
                      pipe.tap_delayed[CODE_W];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fill <= '0;
      data_valid <= 1'b0;
    end else begin
      if (state == S_SLEEP || state == S_CAL) begin
        fill <= '0;
      end else if (pipe.shift && fill < FILL_W'(DELAYED_LATENCY)) begin
        fill <= fill + 1'b1;
      end
      data_valid <= (fill == FILL_W'(DELAYED_LATENCY)) &&
                    (state == S_IDLE);
    end
  end

  assign status_word = {2'b00, ext_s,
                        (state == S_DELAY || state == S_HOLD),
                        data_valid, (state == S_SLEEP), trim_active,
                        calibration_active};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_cmd_starts_cal;
    @(posedge mclk) disable iff (!rst_b)
      (state == S_IDLE && cal_cmd && !sleep_s) |=> ##1 calibration_active;
  endproperty
  a_cmd_starts_cal: assert property (p_cmd_starts_cal)
    else $error("command did not start calibration");

  property p_cal_ends;
    @(posedge mclk) disable iff (!rst_b)
      (state == S_CAL && smp_fall && seq_cnt == cnt_of(CAL_CYCLES - 1))
      |=> ##1 !calibration_active;
  endproperty
  a_cal_ends: assert property (p_cal_ends)
    else $error("calibration did not end after its duration");

  property p_cal_held;
    @(posedge mclk) disable iff (!rst_b)
      (state == S_CAL && seq_cnt < cnt_of(CAL_CYCLES - 1))
      |=> ##1 calibration_active;
  endproperty
  a_cal_held: assert property (p_cal_held)
    else $error("calibration flag dropped early");

  property p_delay_frozen;
    @(posedge mclk) disable iff (!rst_b)
      (state == S_DELAY && sleep_s) |=> $stable(seq_cnt) && state == S_DELAY;
  endproperty
  a_delay_frozen: assert property (p_delay_frozen)
    else $error("delay counted during sleep");

  property p_sleep_ignores;
    @(posedge mclk) disable iff (!rst_b)
      (state == S_SLEEP && sleep_s) |=> state == S_SLEEP && !cal_cmd;
  endproperty
  a_sleep_ignores: assert property (p_sleep_ignores)
    else $error("sleep left or command seen while asleep");

  property p_sleep_floats;
    @(posedge mclk) disable iff (!rst_b)
      (state == S_SLEEP) |=> !output_enable && !calibration_active;
  endproperty
  a_sleep_floats: assert property (p_sleep_floats)
    else $error("outputs driven while asleep");

  property p_trim_halt;
    @(posedge mclk) disable iff (!rst_b)
      trim ##1 trim |-> $stable(forwarded_output_clock) && !pipe.shift;
  endproperty
  a_trim_halt: assert property (p_trim_halt)
    else $error("clock moved during trim");

  property p_no_valid_in_cal;
    @(posedge mclk) disable iff (!rst_b)
      calibration_active |-> ##1 !data_valid;
  endproperty
  a_no_valid_in_cal: assert property (p_no_valid_in_cal)
    else $error("data marked valid during calibration");

  property p_clamp;
    @(posedge mclk) disable iff (!rst_b)
      (below_s || above_s) |->
        pipe.din[CODE_W] &&
        pipe.din[CODE_W-1:0] == (below_s ? CODE_MIN : CODE_MAX);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("out of range code not clamped");

  property p_range_flag;
    @(posedge mclk) disable iff (!rst_b)
      launch |=> out_of_range ==
        ($past(pipe.tap_primary[CODE_W]) | $past(pipe.tap_delayed[CODE_W]));
  endproperty
  a_range_flag: assert property (p_range_flag)
    else $error("range flag does not cover both buses");

  c_cmd_cal: cover property (@(posedge mclk) disable iff (!rst_b)
    state == S_IDLE ##1 state == S_CAL);
  c_sleep_after_cal: cover property (@(posedge mclk) disable iff (!rst_b)
    state == S_CAL ##1 state == S_SLEEP);
  c_hold_path: cover property (@(posedge mclk) disable iff (!rst_b)
    state == S_HOLD ##1 state == S_CAL);
  c_valid: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(data_valid));

endmodule : adc_cal_output_ctrl

// [hw/adc_ctrl_pkg.sv]
// Shared constants and types for the converter control block
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Output word
  // ----------------------------------------------------------------
  localparam int CODE_W = 8;
  // Stored word is the code with its range flag on top
  localparam int WORD_W = CODE_W + 1;
  localparam logic [CODE_W-1:0] CODE_MIN = 8'h00;
  localparam logic [CODE_W-1:0] CODE_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // Pipeline, in sample clocks
  // ----------------------------------------------------------------
  localparam int PRIMARY_LATENCY = 13;
  localparam int DELAYED_LATENCY = 14;
  localparam int FILL_W = 4;

  // ----------------------------------------------------------------
  // Sequencing counts, in sample clocks
  // ----------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int CAL_LOW_MIN_DEF = 80;
  localparam int CAL_HIGH_MIN_DEF = 80;
  localparam int CAL_CYCLES_DEF = 1400;
  localparam int TRIM_CYCLES_DEF = 100;
  localparam int DELAY_SHORT_DEF = 256;
  localparam int DELAY_LONG_DEF = 4096;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 8;
  localparam logic [REG_ADDR_W-1:0] REG_CONFIG = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam int CFG_SWING = 0;
  localparam int CFG_EDGE = 1;
  localparam int CFG_FSR = 2;
  localparam logic [REG_DATA_W-1:0] CFG_RESET = 8'h07;
  localparam int ST_CAL = 0;
  localparam int ST_TRIM = 1;
  localparam int ST_SLEEP = 2;
  localparam int ST_VALID = 3;
  localparam int ST_WAIT = 4;
  localparam int ST_EXT = 5;

  typedef enum logic [2:0] {
    S_CHECK,
    S_DELAY,
    S_HOLD,
    S_IDLE,
    S_CAL,
    S_SLEEP
  } cal_state_e;

endpackage : adc_ctrl_pkg

// [hw/pipe_if.sv]
// Carrier between the control block and its sample delay line
`timescale 1ns/10ps
interface pipe_if #(
  parameter int W = 9
) ();
  logic shift;
  logic [W-1:0] din;
  logic [W-1:0] tap_primary;
  logic [W-1:0] tap_delayed;

  modport feeder (output shift, output din,
                  input tap_primary, input tap_delayed);
  modport line (input shift, input din,
                output tap_primary, output tap_delayed);
endinterface : pipe_if

// [hw/sample_delay_line.sv]
// Sample delay line with two registered taps
`timescale 1ns/10ps
module sample_delay_line
  import adc_ctrl_pkg::*;
#(
  parameter int W = WORD_W,
  parameter int DEPTH = DELAYED_LATENCY,
  parameter int TAP_P = PRIMARY_LATENCY,
  parameter int TAP_D = DELAYED_LATENCY
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Pipeline carrier
  pipe_if.line pipe
);

  logic [W-1:0] mem [DEPTH];

  // Taps read the old contents, so each tap lags its index by one shift
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      pipe.tap_primary <= '0;
      pipe.tap_delayed <= '0;
    end else if (pipe.shift) begin
      mem[0] <= pipe.din;
      for (int i = 1; i < DEPTH; i++) begin
        mem[i] <= mem[i-1];
      end
      pipe.tap_primary <= mem[TAP_P-1];
      pipe.tap_delayed <= mem[TAP_D-1];
    end
  end

endmodule : sample_delay_line

// [tb/capture_model.sv]
// Capture logic that re-interleaves the two half-rate output buses
`timescale 1ns/10ps
module capture_model
  import adc_ctrl_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Converter outputs
  input wire logic [CODE_W-1:0] primary_output_bus,
  input wire logic [CODE_W-1:0] delayed_output_bus,
  input wire logic out_of_range,
  input wire logic forwarded_output_clock,
  input wire logic data_valid,
  input wire logic calibration_active,
  // Output clock level on which the buses are launched
  input wire logic launch_edge,
  // Last captured pair, older word first
  output logic [CODE_W-1:0] older,
  output logic [CODE_W-1:0] newer,
  output logic range_flag,
  output int pairs
);
  logic [2:0] seen = 3'h0;
  logic clk_last = 1'h0;

  initial begin
    older = 8'h00;
    newer = 8'h00;
    range_flag = 1'h0;
    pairs = 0;
  end

  // Take the buses three cycles after a launch edge, when they have settled
  always @(posedge mclk) begin
    clk_last <= forwarded_output_clock;
    seen <= {seen[1:0], forwarded_output_clock != clk_last};
    if (seen[1] && forwarded_output_clock == launch_edge &&
        data_valid && !calibration_active) begin
      older <= delayed_output_bus;
      newer <= primary_output_bus;
      range_flag <= out_of_range;
      pairs <= pairs + 1;
    end
  end
endmodule : capture_model

// [tb/tb_adc_cal_output_ctrl.sv]
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module tb_adc_cal_output_ctrl
  import adc_ctrl_pkg::*;
;
  logic mclk = 1'h0, rst_b = 1'h0, sample_clock = 1'h0, sc_last = 1'h0;
  logic [CODE_W-1:0] core_code = 8'h00;
  logic core_below = 1'h0, core_above = 1'h0;
  logic calibrate = 1'h0, sleep_request = 1'h0;
  logic power_up_delay_select = 1'h0, full_scale_select = 1'h1;
  logic output_swing_select = 1'h1, launch_edge_select = 1'h1;
  logic extended_mode = 1'h0;
  logic [REG_ADDR_W-1:0] reg_addr = 4'h0;
  logic [REG_DATA_W-1:0] reg_wdata = 8'h00, rd, pbus_last;
  logic reg_write = 1'h0, reg_read = 1'h0, forwarded_output_clock_last, lvl;
  logic [REG_DATA_W-1:0] reg_rdata;
  logic [CODE_W-1:0] primary_output_bus, delayed_output_bus, older, newer;
  logic out_of_range, forwarded_output_clock, output_enable, data_valid;
  logic calibration_active, trim_active, output_swing_normal;
  logic full_scale_normal, range_flag;
  int pairs, error_cnt = 0, cmp_count = 0, trim_tog = 0, trim_age = 0;

  adc_cal_output_ctrl #(.CAL_LOW_MIN(3), .CAL_HIGH_MIN(3),
    .CAL_CYCLES(40), .TRIM_CYCLES(5), .DELAY_SHORT(8), .DELAY_LONG(16))
  uut (.mclk, .rst_b, .sample_clock, .core_code, .core_below, .core_above,
    .calibrate, .sleep_request, .power_up_delay_select, .full_scale_select,
    .output_swing_select, .launch_edge_select, .extended_mode, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .primary_output_bus,
    .delayed_output_bus, .out_of_range, .forwarded_output_clock,
    .output_enable, .data_valid, .calibration_active, .trim_active,
    .output_swing_normal, .full_scale_normal);

  capture_model cap (.mclk, .primary_output_bus, .delayed_output_bus,
    .out_of_range, .forwarded_output_clock, .data_valid,
    .calibration_active, .launch_edge(launch_edge_select), .older, .newer,
    .range_flag, .pairs);

  // ----------------------------------------------------------------
  // Clocks, stimulus and monitors
  // ----------------------------------------------------------------
  always #10 mclk = ~mclk;
  // Sample clock offset so its edges never meet the system clock edges
  initial begin
    #3;
    forever #80 sample_clock = ~sample_clock;
  end

  always @(posedge mclk) begin
    sc_last <= sample_clock;
    if (sample_clock && !sc_last) core_code <= core_code + 8'h01;
    trim_age <= trim_active ? trim_age + 1 : 0;
    if (trim_age > 3 && forwarded_output_clock !== forwarded_output_clock_last)
      trim_tog <= trim_tog + 1;
    forwarded_output_clock_last <= forwarded_output_clock;
    if (primary_output_bus !== pbus_last) lvl <= forwarded_output_clock;
    pbus_last <= primary_output_bus;
  end

  initial begin
    #1_000_000;
    error_cnt++;
    end_of_test;
  end

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic flag(logic got, logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : flag

  task automatic samples(int n);
    repeat (n) @(negedge sample_clock);
    @(posedge mclk);
  endtask : samples

  task automatic cal_done;
    for (int k = 0; k < 1000 && calibration_active !== 1'h0; k++)
      @(posedge mclk);
  endtask : cal_done

  task automatic command(int lo, int hi);
    calibrate <= 1'h0;
    samples(lo);
    calibrate <= 1'h1;
    samples(hi);
  endtask : command

  task automatic rd_reg(logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'h0;
    @(posedge mclk);
    d = reg_rdata;
  endtask : rd_reg

  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'h0;
  endtask : wr_reg

  task automatic do_reset;
    @(posedge mclk);
    rst_b <= 1'h0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'h1;
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pwr;
    int n = 0;
    samples(5);
    flag(calibration_active, 1'h0);
    for (int k = 0; k < 400 && calibration_active !== 1'h1; k++)
      @(posedge mclk);
    flag(calibration_active, 1'h1);
    flag(trim_active, 1'h1);
    flag(data_valid, 1'h0);
    while (calibration_active === 1'h1 && n < 99) begin
      @(negedge sample_clock);
      n++;
    end
    flag(n > 38 && n < 43, 1'h1);
    flag(trim_tog == 0, 1'h1);
    $display("power-up test done");
  endtask : t_pwr

  task automatic t_stream;
    int p;
    logic [7:0] d;
    for (int k = 0; k < 40 && data_valid !== 1'h1; k++) samples(1);
    flag(data_valid, 1'h1);
    for (int e = 0; e < 2; e++) begin
      launch_edge_select <= e[0];
      p = pairs;
      samples(20);
      flag(lvl, e[0]);
      flag(pairs - p > 7, 1'h1);
      chk(newer, older + 8'h01);
      d = core_code - newer;
      flag(d > 12 && d < 18, 1'h1);
    end
    flag(range_flag, 1'h0);
    $display("stream test done");
  endtask : t_stream

  task automatic t_range;
    core_above <= 1'h1;
    samples(20);
    chk(newer, CODE_MAX);
    chk(older, CODE_MAX);
    flag(range_flag, 1'h1);
    core_above <= 1'h0;
    core_below <= 1'h1;
    samples(20);
    chk(newer, CODE_MIN);
    flag(range_flag, 1'h1);
    core_below <= 1'h0;
    $display("range test done");
  endtask : t_range

  task automatic t_cmd;
    command(5, 5);
    flag(calibration_active, 1'h1);
    cal_done;
    command(1, 10);
    flag(calibration_active, 1'h0);
    $display("command test done");
  endtask : t_cmd

  task automatic t_regs;
    rd_reg(REG_CONFIG, rd);
    chk(rd, CFG_RESET);
    output_swing_select <= 1'h0;
    full_scale_select <= 1'h0;
    command(5, 5);
    flag(output_swing_normal, 1'h0);
    flag(full_scale_normal, 1'h0);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, rd);
    chk(rd, 8'h00);
    wr_reg(REG_CONFIG, 8'h00);
    rd_reg(REG_CONFIG, rd);
    chk(rd, 8'h00);
    rd_reg(REG_STATUS, rd);
    chk(rd & 8'hE5, 8'h01);
    cal_done;
    $display("register test done");
  endtask : t_regs

  task automatic t_sleep;
    command(5, 5);
    sleep_request <= 1'h1;
    samples(5);
    flag(output_enable, 1'h1);
    flag(calibration_active, 1'h1);
    cal_done;
    samples(1);
    flag(output_enable, 1'h0);
    command(5, 5);
    flag(calibration_active, 1'h0);
    sleep_request <= 1'h0;
    samples(3);
    flag(data_valid, 1'h0);
    samples(20);
    flag(data_valid, 1'h1);
    $display("sleep test done");
  endtask : t_sleep

  task automatic t_hold;
    calibrate <= 1'h1;
    do_reset;
    samples(30);
    flag(calibration_active, 1'h0);
    command(5, 5);
    flag(calibration_active, 1'h1);
    cal_done;
    $display("hold test done");
  endtask : t_hold

  task automatic t_pd;
    calibrate <= 1'h0;
    sleep_request <= 1'h1;
    power_up_delay_select <= 1'h1;
    do_reset;
    samples(30);
    flag(calibration_active, 1'h0);
    flag(output_enable, 1'h0);
    sleep_request <= 1'h0;
    samples(12);
    flag(calibration_active, 1'h0);
    samples(10);
    flag(calibration_active, 1'h1);
    $display("sleep at power-up test done");
  endtask : t_pd

  // Mode changes only across a reset; swing and full-scale pins now disagree with the register
  task automatic t_ext;
    extended_mode <= 1'h1;
    do_reset;
    samples(2);
    flag(output_swing_normal, 1'h1);
    flag(full_scale_normal, 1'h1);
    samples(10);
    flag(calibration_active, 1'h1);
    wr_reg(REG_CONFIG, 8'h00);
    rd_reg(REG_STATUS, rd);
    chk(rd & 8'h20, 8'h20);
    flag(output_swing_normal, 1'h0);
    flag(full_scale_normal, 1'h0);
    cal_done;
    $display("extended mode test done");
  endtask : t_ext

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    do_reset;
    t_pwr;
    t_stream;
    t_range;
    t_cmd;
    t_regs;
    t_sleep;
    t_hold;
    t_pd;
    t_ext;
    end_of_test;
  end
endmodule : tb_adc_cal_output_ctrl
